// file: wwd_pkg.sv
// Purpose: Shared constants for the windowed watchdog timer
// Assumes: 200 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
`default_nettype none
package wwd_pkg;
	// ==========================================================
	// Timing
	// ==========================================================
	localparam int unsigned CLK_FREQ_HZ  = 200_000_000;
	localparam int unsigned LOW_POWER_RC_CLOCK_FREQ_HZ = 32_000;       // Nominal low-power RC rate
	localparam int unsigned LOW_POWER_RC_CLOCK_DIV     = CLK_FREQ_HZ / LOW_POWER_RC_CLOCK_FREQ_HZ;
	localparam int unsigned PRE_SHORT    = 32;
	localparam int unsigned PRE_LONG     = 128;
	localparam int unsigned PRE_W        = 7;
	localparam int unsigned POST_W       = 15;
	localparam int unsigned POST_SEL_W   = 4;

	// ==========================================================
	// Register offsets
	// ==========================================================
	localparam logic [7:0] REG_CONFIG   = 8'h00;  // watchdog_config_word
	localparam logic [7:0] REG_RESCTL   = 8'h04;  // reset_control_register
	localparam logic [7:0] REG_COMMAND  = 8'h08;
	localparam logic [7:0] REG_STATUS   = 8'h0c;
	localparam logic [7:0] REG_COUNT    = 8'h10;
	localparam logic [7:0] REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] REG_IRQ_MASK = 8'h18;

	// ==========================================================
	// Field positions and reset values
	// ==========================================================
	localparam int unsigned CFG_FORCE_BIT  = 0;  // hw_force_enable
	localparam int unsigned CFG_WINOFF_BIT = 1;  // window_mode_off
	localparam int unsigned CFG_PRE_BIT    = 2;  // prescale_select, 1 = 1:128
	localparam int unsigned CFG_POST_LSB   = 4;  // postscale_select
	localparam logic [7:0]  CFG_RESET      = 8'hf6;

	localparam int unsigned RC_IDLE_BIT  = 2;
	localparam int unsigned RC_SLEEP_BIT = 3;
	localparam int unsigned RC_TO_BIT    = 4;  // timeout_flag
	localparam int unsigned RC_SWEN_BIT  = 5;  // sw_enable_bit

	localparam int unsigned CMD_CLEAR_BIT = 0;  // watchdog_clear_instruction
	localparam int unsigned CMD_SLEEP_BIT = 1;  // power_save_instruction, sleep
	localparam int unsigned CMD_IDLE_BIT  = 2;  // power_save_instruction, idle
	localparam int unsigned CMD_CKSW_BIT  = 3;  // Clock switch completed

	localparam int unsigned IRQ_W         = 3;
	localparam int unsigned IRQ_TO_BIT    = 0;
	localparam int unsigned IRQ_WAKE_BIT  = 1;
	localparam int unsigned IRQ_EARLY_BIT = 2;

	typedef enum logic [1:0] {WWD_RUN, WWD_SLEEP, WWD_IDLE} wwd_pwr_e;
endpackage
`default_nettype wire

// file: wwd_tick_gen.sv
// Purpose: Divides the system clock down to the slow watchdog clock rate
// Assumes: run_i low stops and clears the divider
// Notes:   tick_o is a one-cycle pulse per slow clock period
`timescale 1ns/1ps
`default_nettype none
module wwd_tick_gen
	import wwd_pkg::*;
#(
	parameter int unsigned DIV = LOW_POWER_RC_CLOCK_DIV
)(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	output logic      tick_o
);
	localparam logic [15:0] LAST = 16'(DIV - 1);
	logic [15:0] cnt;

	// ==========================================================
	// Free divider, held at zero while the oscillator is off
	// ==========================================================
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt    <= 16'h0000;
			tick_o <= 1'b0;
		end
		else if (!run_i)
		begin
			cnt    <= 16'h0000;
			tick_o <= 1'b0;
		end
		else
		begin
			tick_o <= (cnt == LAST);
			cnt    <= (cnt == LAST) ? 16'h0000 : cnt + 16'h0001;
		end
	end
endmodule // wwd_tick_gen
`default_nettype wire

// file: wwd_scaler.sv
// Purpose: Watchdog prescaler and postscaler with window detection
// Assumes: tick_i is one pulse per slow clock period
// Notes:   clear_i wins over a tick in the same cycle
`timescale 1ns/1ps
`default_nettype none
module wwd_scaler
	import wwd_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  clear_i,
	input  wire logic                  tick_i,
	input  wire logic                  pre_sel_i,
	input  wire logic [POST_SEL_W-1:0] post_sel_i,
	output logic                       timeout_o,
	output logic                       in_window_o,
	output logic [POST_W-1:0]          post_cnt_o
);
	logic [PRE_W-1:0]  pre_cnt;
	logic [PRE_W-1:0]  pre_last;
	logic [POST_W-1:0] post_last;
	logic [23:0]       elapsed;
	logic [23:0]       total;
	logic              pre_wrap;

	// Division ratios from the configuration
	assign pre_last  = pre_sel_i ? PRE_W'(PRE_LONG - 1) : PRE_W'(PRE_SHORT - 1);
	assign post_last = POST_W'((32'h1 << post_sel_i) - 32'h1);
	assign pre_wrap  = tick_i && (pre_cnt == pre_last);

	// Elapsed slow ticks versus full period; last quarter opens the window
	assign elapsed = pre_sel_i ? {2'b00, post_cnt_o, pre_cnt}
	                           : {4'h0, post_cnt_o, pre_cnt[4:0]};
	assign total   = pre_sel_i ? 24'(32'(PRE_LONG) << post_sel_i)
	                           : 24'(32'(PRE_SHORT) << post_sel_i);
	assign in_window_o = ({elapsed, 2'b00} >= ({1'b0, total, 1'b0} + {2'b00, total}));

	// ==========================================================
	// Counters
	// ==========================================================
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pre_cnt    <= '0;
			post_cnt_o <= '0;
			timeout_o  <= 1'b0;
		end
		else if (clear_i)
		begin
			pre_cnt    <= '0;
			post_cnt_o <= '0;
			timeout_o  <= 1'b0;
		end
		else
		begin
			timeout_o <= pre_wrap && (post_cnt_o == post_last);
			if (tick_i)
				pre_cnt <= pre_wrap ? '0 : pre_cnt + PRE_W'(1);
			if (pre_wrap)
				post_cnt_o <= (post_cnt_o == post_last) ? '0
				              : post_cnt_o + POST_W'(1);
		end
	end
endmodule // wwd_scaler
`default_nettype wire

// file: wwd_top.sv
// Purpose: Windowed watchdog timer with APB register access
// Assumes: Single 200 MHz clock; CPU power-save and reset logic outside
// Notes:   Slow watchdog clock is derived here as a tick enable
//          Commands are write-only pulses; status and count are read-only
//          Limitation: config is a writable copy, not a one-time fuse
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wwd_top
	import wwd_pkg::*;
#(
	parameter int unsigned LOW_POWER_RC_CLOCK_DIVIDE = LOW_POWER_RC_CLOCK_DIV
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Device side
	input  wire logic        device_reset_i,
	input  wire logic        wake_other_i,
	output logic             low_power_rc_clock_enable_o,
	output logic             wdt_reset_o,
	output logic             wake_o,
	output logic             cpu_sleep_o,
	output logic             cpu_idle_o,
	output logic             irq_o
);
	logic [7:0]        cfg;
	logic              sw_en;
	logic              to_flag;
	logic              sleep_flag;
	logic              idle_flag;
	logic [IRQ_W-1:0]  irq_stat;
	logic [IRQ_W-1:0]  irq_mask;
	wwd_pwr_e          pwr;
	logic              enabled;
	logic              tick;
	logic              timeout;
	logic              in_window;
	logic [POST_W-1:0] post_cnt;
	logic              scaler_clear;
	logic              wr_en;
	logic              rd_setup;
	logic              mapped;
	logic              cmd_clear;
	logic              cmd_sleep;
	logic              cmd_idle;
	logic              cmd_cksw;
	logic              early_clear;
	logic              run_timeout;
	logic              ps_timeout;
	logic              ps_exit;
	logic              any_reset;
	logic [31:0]       next_rdata;

	// ==========================================================
	// APB decode
	// ==========================================================
	// Zero-wait slave; read data latched in setup so it comes from a flop
	assign pready_o = 1'b1;
	assign wr_en    = psel_i && penable_i && pwrite_i && mapped;
	assign rd_setup = psel_i && !penable_i && !pwrite_i;
	assign mapped   = (paddr_i == REG_CONFIG) || (paddr_i == REG_RESCTL)
	               || (paddr_i == REG_COMMAND) || (paddr_i == REG_STATUS)
	               || (paddr_i == REG_COUNT) || (paddr_i == REG_IRQ_STAT)
	               || (paddr_i == REG_IRQ_MASK);
	assign pslverr_o = psel_i && penable_i && !mapped;

	// Command strobes, one cycle each
	assign cmd_clear = wr_en && (paddr_i == REG_COMMAND) && pwdata_i[CMD_CLEAR_BIT];
	assign cmd_sleep = wr_en && (paddr_i == REG_COMMAND) && pwdata_i[CMD_SLEEP_BIT];
	assign cmd_idle  = wr_en && (paddr_i == REG_COMMAND) && pwdata_i[CMD_IDLE_BIT]
	                && !pwdata_i[CMD_SLEEP_BIT];
	assign cmd_cksw  = wr_en && (paddr_i == REG_COMMAND) && pwdata_i[CMD_CKSW_BIT];

	// ==========================================================
	// Enable and event logic
	// ==========================================================
	assign enabled       = cfg[CFG_FORCE_BIT] || sw_en;
	assign low_power_rc_clock_enable_o = enabled;

	// Early clear only counts while running and window mode is on
	assign early_clear = cmd_clear && enabled && (pwr == WWD_RUN)
	                  && !cfg[CFG_WINOFF_BIT] && !in_window;
	assign run_timeout = timeout && enabled && (pwr == WWD_RUN);
	assign ps_timeout  = timeout && enabled && (pwr != WWD_RUN);
	assign ps_exit     = (pwr != WWD_RUN) && (ps_timeout || wake_other_i);
	assign any_reset   = device_reset_i || wdt_reset_o;

	// Counts restart on every listed event; held clear while disabled
	assign scaler_clear = any_reset || cmd_cksw
	                   || ((cmd_sleep || cmd_idle) && (pwr == WWD_RUN))
	                   || ps_exit
	                   || (cmd_clear && (pwr == WWD_RUN))
	                   || !enabled;

	// ==========================================================
	// Slow clock and scaler chain
	// ==========================================================
	// Divider stops with the oscillator so a disabled watchdog draws no tick
	wwd_tick_gen #(
		.DIV (LOW_POWER_RC_CLOCK_DIVIDE)
	) u_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (enabled),
		.tick_o (tick)
	);

	wwd_scaler u_scaler (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.clear_i     (scaler_clear),
		.tick_i      (tick),
		.pre_sel_i   (cfg[CFG_PRE_BIT]),
		.post_sel_i  (cfg[CFG_POST_LSB +: POST_SEL_W]),
		.timeout_o   (timeout),
		.in_window_o (in_window),
		.post_cnt_o  (post_cnt)
	);

	// ==========================================================
	// Configuration word
	// ==========================================================
	// Writable copy of the fuse word; survives device resets
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cfg <= CFG_RESET;
		else if (wr_en && (paddr_i == REG_CONFIG))
			cfg <= pwdata_i[7:0] & 8'hf7;
	end

	// ==========================================================
	// Software enable
	// ==========================================================
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			sw_en <= 1'b0;
		else if (any_reset)
			sw_en <= 1'b0;
		else if (wr_en && (paddr_i == REG_RESCTL))
			sw_en <= pwdata_i[RC_SWEN_BIT];
	end

	// ==========================================================
	// Sticky status flags
	// ==========================================================
	// Software may only clear; a same-cycle hardware set wins
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			to_flag    <= 1'b0;
			sleep_flag <= 1'b0;
			idle_flag  <= 1'b0;
		end
		else
		begin
			to_flag <= (to_flag && !(wr_en && (paddr_i == REG_RESCTL)
			            && !pwdata_i[RC_TO_BIT]))
			        || run_timeout || ps_timeout;
			sleep_flag <= (sleep_flag && !(wr_en && (paddr_i == REG_RESCTL)
			               && !pwdata_i[RC_SLEEP_BIT]))
			           || (cmd_sleep && (pwr == WWD_RUN));
			idle_flag <= (idle_flag && !(wr_en && (paddr_i == REG_RESCTL)
			              && !pwdata_i[RC_IDLE_BIT]))
			          || (cmd_idle && (pwr == WWD_RUN));
		end
	end

	// ==========================================================
	// Power state
	// ==========================================================
	// Reset sources win; a wake source only matters in a save state
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			pwr <= WWD_RUN;
		else if (any_reset)
			pwr <= WWD_RUN;
		else
		begin
			case (pwr)
				WWD_RUN:
				begin
					if (cmd_sleep)
						pwr <= WWD_SLEEP;
					else if (cmd_idle)
						pwr <= WWD_IDLE;
				end
				WWD_SLEEP, WWD_IDLE:
				begin
					if (ps_exit)
						pwr <= WWD_RUN;
				end
				default:
					pwr <= WWD_RUN;
			endcase
		end
	end

	// ==========================================================
	// Reset and wake pulses
	// ==========================================================
	// Registered pulses; a second reset cycle is suppressed so the pulse
	// width never depends on how long the cause stays high
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wdt_reset_o <= 1'b0;
			wake_o      <= 1'b0;
		end
		else
		begin
			wdt_reset_o <= !wdt_reset_o && (run_timeout || early_clear);
			wake_o      <= ps_exit;
		end
	end

	// Status to the CPU power controller, straight from the state register
	assign cpu_sleep_o = (pwr == WWD_SLEEP);
	assign cpu_idle_o  = (pwr == WWD_IDLE);

	// ==========================================================
	// Interrupt status and mask
	// ==========================================================
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_stat <= '0;
		else
			irq_stat <= (irq_stat & ~((wr_en && (paddr_i == REG_IRQ_STAT))
			             ? pwdata_i[IRQ_W-1:0] : {IRQ_W{1'b0}}))
			          | {early_clear, ps_exit, run_timeout || ps_timeout};
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_mask <= '0;
		else if (wr_en && (paddr_i == REG_IRQ_MASK))
			irq_mask <= pwdata_i[IRQ_W-1:0];
	end

	assign irq_o = |(irq_stat & irq_mask);

	// ==========================================================
	// Read mux
	// ==========================================================
	// Unmapped offsets read as zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (paddr_i)
			REG_CONFIG:   next_rdata[7:0] = cfg;
			REG_RESCTL:
			begin
				next_rdata[RC_SWEN_BIT]  = sw_en;
				next_rdata[RC_TO_BIT]    = to_flag;
				next_rdata[RC_SLEEP_BIT] = sleep_flag;
				next_rdata[RC_IDLE_BIT]  = idle_flag;
			end
			REG_STATUS:   next_rdata[3:0] = {in_window, cpu_idle_o, cpu_sleep_o, enabled};
			REG_COUNT:    next_rdata[POST_W-1:0] = post_cnt;
			REG_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
			REG_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
			default:      next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			prdata_o <= 32'h0000_0000;
		else if (rd_setup)
			prdata_o <= next_rdata;
	end
endmodule // wwd_top
`default_nettype wire

// file: wwd_top_sva.sv
// Purpose: Port-level assertions for the windowed watchdog timer
// Assumes: One clock, rst_i async active high
// Notes:   Register state is inferred from APB writes seen at the ports
`timescale 1ns/1ps
`default_nettype none
module wwd_top_sva
	import wwd_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        device_reset_i,
	input wire logic        wake_other_i,
	input wire logic        low_power_rc_clock_enable_o,
	input wire logic        wdt_reset_o,
	input wire logic        wake_o,
	input wire logic        cpu_sleep_o,
	input wire logic        cpu_idle_o,
	input wire logic        irq_o
);
	// ==========================================================
	// Helpers
	// ==========================================================
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic wr;
	logic run;
	// Access phase write and plain run state
	assign wr = psel_i && penable_i && pwrite_i;
	assign run = !cpu_sleep_o && !cpu_idle_o && !device_reset_i && !wake_other_i;
	// ==========================================================
	// Properties
	// ==========================================================
	a_ready_const: assert property (pready_o) else $error("pready low");
	a_err_unmapped: assert property (psel_i && penable_i |->
		pslverr_o == (paddr_i > REG_IRQ_MASK || paddr_i[1:0] != 2'h0))
		else $error("pslverr wrong");
	a_reset_single: assert property (wdt_reset_o |=> !wdt_reset_o)
		else $error("reset pulse too long");
	a_wake_single: assert property (wake_o |=> !wake_o)
		else $error("wake pulse too long");
	a_save_no_reset: assert property (cpu_sleep_o || cpu_idle_o |-> !wdt_reset_o)
		else $error("reset during power save");
	a_wake_to_run: assert property (wake_o |=> !cpu_sleep_o && !cpu_idle_o)
		else $error("no run after wake");
	a_sleep_entry: assert property (wr && paddr_i == REG_COMMAND && pwdata_i[1] && run
		&& !wdt_reset_o |=> cpu_sleep_o)
		else $error("sleep not entered");
	a_idle_entry: assert property (wr && paddr_i == REG_COMMAND && pwdata_i[2:1] == 2'h2
		&& run && !wdt_reset_o |=> cpu_idle_o)
		else $error("idle not entered");
	a_mask_off: assert property (wr && paddr_i == REG_IRQ_MASK && pwdata_i[2:0] == 3'h0
		|=> !irq_o) else $error("irq while masked");
	// Enable moves only after a write, a watchdog reset or a device reset
	a_low_power_rc_clock_cause: assert property (!$stable(low_power_rc_clock_enable_o) |-> $past(wr) || $past(wdt_reset_o)
		|| $past(wdt_reset_o, 2) || $past(device_reset_i) || $past(device_reset_i, 2))
		else $error("low_power_rc_clock enable moved alone");
endmodule // wwd_top_sva
bind wwd_top wwd_top_sva wwd_top_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .device_reset_i(device_reset_i),
	.wake_other_i(wake_other_i), .low_power_rc_clock_enable_o(low_power_rc_clock_enable_o), .wdt_reset_o(wdt_reset_o),
	.wake_o(wake_o), .cpu_sleep_o(cpu_sleep_o), .cpu_idle_o(cpu_idle_o), .irq_o(irq_o));
`default_nettype wire

// file: tb_top.sv
// Purpose: Self-checking bench for the windowed watchdog timer
// Assumes: LOW_POWER_RC_CLOCK_DIVIDE set to 4, so one slow tick is 4 clocks
// Notes:   Pulses are counted by a monitor so APB traffic cannot hide them
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import wwd_pkg::*;
;
	localparam int DIV = 4;
	logic        clk_i, rst_i, psel, pen, pwr, dres, woth, pready, err;
	logic        pslverr, low_power_rc_clock, wrst, wake, slp, idl, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          bad_count, check_count, cyc, n_rst, n_wake, t0, e, b, bw, k;
	wwd_top #(.LOW_POWER_RC_CLOCK_DIVIDE(DIV)) wwd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .device_reset_i(dres),
		.wake_other_i(woth), .low_power_rc_clock_enable_o(low_power_rc_clock), .wdt_reset_o(wrst), .wake_o(wake),
		.cpu_sleep_o(slp), .cpu_idle_o(idl), .irq_o(irq));
	// ==========================================================
	// Clock and pulse monitor
	// ==========================================================
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// One-cycle pulses are caught at every rising edge
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (wrst === 1'b1) n_rst <= n_rst + 1;
		if (wake === 1'b1) n_wake <= n_wake + 1;
	end
	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Setup, then access until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk_i);
		pen <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 20)
		begin
			bad_count++;
			print_verdict();
		end
	endtask
	// Wait until a pulse count moves past its base
	task automatic wait_ev(input bit wk, input int base, input int lim);
		int n;
		n = 0;
		while ((wk ? n_wake : n_rst) == base && n < lim)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= lim)
		begin
			bad_count++;
			print_verdict();
		end
	endtask
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		{psel, pen, pwr, dres, woth, paddr, pwdata, bad_count, check_count} = '0;
		{cyc, n_rst, n_wake} = '0;
		rst_i = 1'b1;
		void'($urandom(32'h802f12a7));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		apb(0, REG_CONFIG, 0);
		chk(rd, {24'h0, CFG_RESET});
		apb(0, REG_RESCTL, 0);
		chk(rd, 32'h0);
		apb(0, 8'h1c, 0);
		chk({rd[30:0], err}, 32'h1);
		chk(low_power_rc_clock, 1'b0);
		// Random mask pattern must read back through its own width
		k = $urandom;
		apb(1, REG_IRQ_MASK, k);
		apb(0, REG_IRQ_MASK, 0);
		chk(rd, 32'(k) & ((32'h1 << IRQ_W) - 32'h1));
		$display("test reset values done");
		// Period for both prescale choices with postscale 0, and for 1:32 with postscale 3
		for (int i = 0; i < 3; i++)
		begin
			apb(1, REG_IRQ_MASK, i == 1 ? 0 : 1);
			apb(1, REG_CONFIG, ((i == 2 ? 3 : 0) << 4) | (i == 1 ? 6 : 2));
			b = n_rst;
			apb(1, REG_RESCTL, 32'h20);
			t0 = cyc;
			@(posedge clk_i);
			chk(low_power_rc_clock, 1'b1);
			wait_ev(0, b, 5000);
			e = (i == 1 ? 128 : 32) * (i == 2 ? 8 : 1) * DIV;
			chk(cyc - t0 >= e - DIV && cyc - t0 <= e + 8, 1'b1);
			chk(irq, i != 1);
			apb(0, REG_RESCTL, 0);
			chk(rd, 32'h10);
			apb(1, REG_IRQ_STAT, 7);
			@(posedge clk_i);
			chk(irq, 1'b0);
			apb(1, REG_RESCTL, 0);
			apb(0, REG_RESCTL, 0);
			chk(rd, 32'h0);
		end
		$display("test periods done");
		apb(1, REG_CONFIG, 3);
		@(posedge clk_i);
		chk(low_power_rc_clock, 1'b1);
		b = n_rst;
		wait_ev(0, b, 400);
		@(posedge clk_i) dres <= 1'b1;
		@(posedge clk_i) dres <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(low_power_rc_clock, 1'b1);
		apb(1, REG_CONFIG, 2);
		@(posedge clk_i);
		chk(low_power_rc_clock, 1'b0);
		apb(1, REG_RESCTL, 0);
		$display("test force enable done");
		// Clears and clock switches at random spacing hold off the time-out
		apb(1, REG_CONFIG, 32'h22);
		apb(1, REG_RESCTL, 32'h20);
		b = n_rst;
		for (int i = 0; i < 6; i++)
		begin
			repeat (100 + $urandom % 300) @(posedge clk_i);
			apb(1, REG_COMMAND, i[0] ? 8 : 1);
		end
		chk(n_rst, b);
		@(posedge clk_i) dres <= 1'b1;
		@(posedge clk_i) dres <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(low_power_rc_clock, 1'b0);
		$display("test clears done");
		// Sleep then idle: time-out wakes without reset
		apb(1, REG_CONFIG, 2);
		for (int s = 0; s < 2; s++)
		begin
			apb(1, REG_RESCTL, 32'h20);
			b = n_rst;
			bw = n_wake;
			apb(1, REG_COMMAND, s ? 4 : 2);
			@(posedge clk_i);
			chk({slp, idl}, s ? 2'h1 : 2'h2);
			wait_ev(1, bw, 400);
			repeat (2) @(posedge clk_i);
			chk(n_rst, b);
			chk({slp, idl}, 2'h0);
			// Wake event bit is cleared each pass so the second pass can trip it
			apb(0, REG_IRQ_STAT, 0);
			chk(rd[IRQ_WAKE_BIT], 1'b1);
			apb(1, REG_IRQ_STAT, 32'h2);
			apb(1, REG_RESCTL, 32'h1c);
			repeat (200) @(posedge clk_i);
			apb(0, REG_RESCTL, 0);
			chk(rd, s ? 32'h14 : 32'h18);
			apb(1, REG_RESCTL, 0);
			apb(0, REG_RESCTL, 0);
			chk(rd, 32'h0);
		end
		bw = n_wake;
		apb(1, REG_COMMAND, 2);
		@(posedge clk_i) woth <= 1'b1;
		@(posedge clk_i) woth <= 1'b0;
		wait_ev(1, bw, 20);
		repeat (2) @(posedge clk_i);
		chk(slp, 1'b0);
		apb(1, REG_RESCTL, 0);
		$display("test power save done");
		// Window mode: early clear resets, clear in last quarter does not
		apb(1, REG_CONFIG, 0);
		apb(1, REG_RESCTL, 32'h20);
		b = n_rst;
		apb(1, REG_COMMAND, 1);
		wait_ev(0, b, 10);
		chk(n_rst, b + 1);
		apb(0, REG_IRQ_STAT, 0);
		chk(rd[2], 1'b1);
		apb(1, REG_RESCTL, 32'h20);
		k = 0;
		do
		begin
			apb(0, REG_STATUS, 0);
			k++;
		end
		while (rd[3] !== 1'b1 && k < 60);
		chk(rd[3], 1'b1);
		b = n_rst;
		apb(1, REG_COMMAND, 1);
		repeat (5) @(posedge clk_i);
		chk(n_rst, b);
		apb(1, REG_RESCTL, 0);
		$display("test window done");
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
